// [hw/tmc_defs.vh]
// Constants for the transceiver mode control block
`ifndef TMC_DEFS_VH
`define TMC_DEFS_VH

`define TMC_CLK_NS          40
// Last index of each interval in 40 ns cycles, sized to the counter that meets it
`define TMC_CLKTAIL_NS      6000
`define TMC_CLKTAIL_LAST    8'h95
`define TMC_CAL_RUN_NS      20000
`define TMC_CAL_RUN_LAST    10'h1f3
`define TMC_CAL_TICK_NS     100000
`define TMC_CAL_TICK_LAST   12'h9c3

`define TMC_SER_BITS        5'h18
`define TMC_SER_SEL_BIT     23
`define TMC_FREQ_MSB        22

`define TMC_CFG_TEST_LSB    0
`define TMC_CFG_TEST_MSB    2
`define TMC_CFG_RATE_LSB    3
`define TMC_CFG_RATE_MSB    5
`define TMC_CFG_PINSEL_BIT  6
`define TMC_CFG_CLKREC_BIT  7
`define TMC_CFG_RESET       16'h0000
`define TMC_FREQ_RESET      23'h000000

`define TMC_TEST_SLICER_A   3'h4
`define TMC_TEST_SLICER_B   3'h5

`define TMC_RATE_576K       3'h0
`define TMC_RATE_1152K      3'h1
`define TMC_RATE_1536K      3'h2
`define TMC_IF_864K         2'h0
`define TMC_IF_1024K        2'h1
`define TMC_IF_2048K        2'h2

`define TMC_ADDR_CTRL       12'h000
`define TMC_ADDR_STATUS     12'h004
`define TMC_ADDR_CONFIG     12'h008
`define TMC_ADDR_FREQ       12'h00c
`define TMC_CTRL_RESET      16'h0000
`define TMC_CTRL_FORCE_BIT  16

`endif

// [hw/tmc_serial_loader.v]
// Three-wire serial configuration word receiver
`include "tmc_defs.vh"

module tmc_serial_loader (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        ser_clk,
    input  wire        ser_data,
    input  wire        ser_en,
    output reg         wordValid,
    output reg  [23:0] word
);
    reg        clkPrev;
    reg        enPrev;
    reg [23:0] shiftReg;
    reg [4:0]  bitCount;

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            clkPrev   <= 1'b0;
            enPrev    <= 1'b1;
            shiftReg  <= 24'h000000;
            bitCount  <= 5'h00;
            wordValid <= 1'b0;
            word      <= 24'h000000;
        end
        else
        begin
            clkPrev   <= ser_clk;
            enPrev    <= ser_en;
            wordValid <= 1'b0;
            // Data only shifts while the enable is low, MSB first
            if (ser_clk && !clkPrev && !ser_en && !enPrev)
            begin
                shiftReg <= {shiftReg[22:0], ser_data};
                if (bitCount != 5'h1f)
                    bitCount <= bitCount + 5'h01;
            end
            if (ser_en && !enPrev)
            begin
                // A short or long word is dropped rather than half-applied
                if (bitCount == `TMC_SER_BITS)
                begin
                    word      <= shiftReg;
                    wordValid <= 1'b1;
                end
                bitCount <= 5'h00;
            end
        end
    end
endmodule // tmc_serial_loader

// [hw/tmc_mode_ctrl.v]
// Transceiver mode, switch, lock pin, recovered clock and calibration control
// Summary of operation
// - Chip enable low forces standby regardless of receive select.
// - With chip enable high, receive select high gives receive, low transmit.
// - Serial interface and registers stay live and writable in standby.
// - Negative switch output is low in transmit, high in receive, unless the pin select bit gives it the recovered clock.
// - Recovered clock runs on briefly after receive select falls, then holds high.
// - Test field 4 or 5 makes lock pin a slicer time constant input.
// - Otherwise the lock pin outputs synthesizer lock state.
// - Power amplifier stays off in transmit until the synthesizer locks.
// - A 23-bit synthesizer frequency word is accepted in any mode.
// - Self-calibration runs after power-on and at periodic intervals.
// - Clock recovery is offered only at the four higher data rates.
// - Data rate selects the receive intermediate frequency.
// - In receive the sliced data appears as NRZ on the data output.
// - Positive switch output is high in transmit, low in receive.
// - Both switch outputs are inactive while the synthesizer is unlocked, except the negative one while the pin select bit gives it the recovered clock.
// - Registers load on serial enable rising; data ignored while enable high.
`include "tmc_defs.vh"

module tmc_mode_ctrl (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire        chip_enable_pin,
    input  wire        receive_select_pin,
    input  wire        ser_clk,
    input  wire        ser_data,
    input  wire        ser_en,
    input  wire        synth_locked,
    input  wire        slicer_bit,
    input  wire        recovered_clock_raw,
    input  wire        slicer_tc_select_in,
    output reg         slicer_tc_select_out,
    output reg         slicer_tc_select_oe,
    output reg         slicer_tc_long,
    output reg         tr_switch_pos_out,
    output reg         tr_switch_neg_out,
    output reg         power_amplifier_en,
    output reg         receiver_power_en,
    output reg         transmitter_power_en,
    output reg         calibration_active,
    output reg  [1:0]  if_freq_select,
    output reg         data_out_pin,
    output reg  [22:0] synth_freq_word
);
    localparam [1:0] ST_STANDBY = 2'h0;
    localparam [1:0] ST_CAL     = 2'h1;
    localparam [1:0] ST_RX      = 2'h2;
    localparam [1:0] ST_TX      = 2'h3;

    function [1:0] rate_to_if;
        input [2:0] rate;
        begin
            if (rate == `TMC_RATE_576K || rate == `TMC_RATE_1152K)
                rate_to_if = `TMC_IF_864K;
            else if (rate == `TMC_RATE_1536K)
                rate_to_if = `TMC_IF_1024K;
            else
                rate_to_if = `TMC_IF_2048K;
        end
    endfunction

    function slicer_mode;
        input [2:0] test;
        begin
            slicer_mode = (test == `TMC_TEST_SLICER_A) || (test == `TMC_TEST_SLICER_B);
        end
    endfunction

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [15:0] cfgReg;
    reg  [15:0] calInterval;
    reg  [15:0] calElapsed;
    reg  [11:0] tickCount;
    reg  [9:0]  calCount;
    reg  [7:0]  tailCount;
    reg         calPending;
    reg         firstCalDone;
    reg         rxSelPrev;
    reg         clockTailOn;
    wire        serValid;
    wire [23:0] serWord;
    wire        tick;
    wire        apbWrite;
    wire        apbSetup;
    wire        addrHit;
    wire [2:0]  testField;
    wire [2:0]  rateField;
    wire        clockRecOk;
    wire        calRequest;

    tmc_serial_loader u_loader (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ser_clk   (ser_clk),
        .ser_data  (ser_data),
        .ser_en    (ser_en),
        .wordValid (serValid),
        .word      (serWord)
    );

    assign testField = cfgReg[`TMC_CFG_TEST_MSB:`TMC_CFG_TEST_LSB];
    assign rateField = cfgReg[`TMC_CFG_RATE_MSB:`TMC_CFG_RATE_LSB];
    // Lowest rate has no clock recovery
    assign clockRecOk = cfgReg[`TMC_CFG_CLKREC_BIT] && (rateField != `TMC_RATE_576K);

    // Serial words land whatever the mode, so standby keeps programming alive
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cfgReg          <= `TMC_CFG_RESET;
            synth_freq_word <= `TMC_FREQ_RESET;
        end
        else if (serValid)
        begin
            if (serWord[`TMC_SER_SEL_BIT])
                synth_freq_word <= serWord[`TMC_FREQ_MSB:0];
            else
                cfgReg <= serWord[15:0];
        end
    end

    // APB slave: zero wait states, read data captured in the setup phase
    assign pready   = 1'b1;
    assign apbSetup = psel && !penable;
    assign apbWrite = psel && penable && pwrite;
    assign addrHit  = (paddr == `TMC_ADDR_CTRL) || (paddr == `TMC_ADDR_STATUS) ||
                      (paddr == `TMC_ADDR_CONFIG) || (paddr == `TMC_ADDR_FREQ);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (apbSetup)
        begin
            pslverr <= !addrHit;
            case (paddr)
                `TMC_ADDR_CTRL:   prdata <= {16'h0000, calInterval};
                `TMC_ADDR_STATUS: prdata <= {23'h000000, if_freq_select, clockRecOk,
                                             calibration_active, power_amplifier_en,
                                             synth_locked, firstCalDone, state};
                `TMC_ADDR_CONFIG: prdata <= {16'h0000, cfgReg};
                `TMC_ADDR_FREQ:   prdata <= {9'h000, synth_freq_word};
                default:          prdata <= 32'h00000000;
            endcase
        end
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
            calInterval <= `TMC_CTRL_RESET;
        else if (apbWrite && paddr == `TMC_ADDR_CTRL)
            calInterval <= pwdata[15:0];
    end

    // Interval tick divider
    assign tick = (tickCount == `TMC_CAL_TICK_LAST);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
            tickCount <= 12'h000;
        else if (tick)
            tickCount <= 12'h000;
        else
            tickCount <= tickCount + 12'h001;
    end

    // Calibration requests: power-on, interval expiry, config write, forced, receive select rising
    assign calRequest = (calInterval != 16'h0000 && tick && calElapsed >= calInterval - 16'h0001)
                      || (serValid && !serWord[`TMC_SER_SEL_BIT])
                      || (apbWrite && paddr == `TMC_ADDR_CTRL && pwdata[`TMC_CTRL_FORCE_BIT])
                      || (receive_select_pin && !rxSelPrev);

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            calElapsed <= 16'h0000;
            calPending <= 1'b1;
            rxSelPrev  <= 1'b0;
        end
        else
        begin
            rxSelPrev <= receive_select_pin;
            if (state == ST_CAL)
                calElapsed <= 16'h0000;
            else if (tick && calElapsed != 16'hffff)
                calElapsed <= calElapsed + 16'h0001;
            // A new request in the cycle the pending one is taken still wins
            if (calRequest)
                calPending <= 1'b1;
            else if (state == ST_CAL)
                calPending <= 1'b0;
        end
    end

    always @*
    begin
        next_state = state;
        case (state)
            ST_STANDBY:
            begin
                if (chip_enable_pin)
                    next_state = calPending ? ST_CAL : (receive_select_pin ? ST_RX : ST_TX);
            end
            ST_CAL:
            begin
                if (!chip_enable_pin)
                    next_state = ST_STANDBY;
                else if (calCount == `TMC_CAL_RUN_LAST)
                    next_state = receive_select_pin ? ST_RX : ST_TX;
            end
            ST_RX, ST_TX:
            begin
                if (!chip_enable_pin)
                    next_state = ST_STANDBY;
                else if (calPending)
                    next_state = ST_CAL;
                else
                    next_state = receive_select_pin ? ST_RX : ST_TX;
            end
            default:
                next_state = ST_STANDBY;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state        <= ST_STANDBY;
            calCount     <= 10'h000;
            firstCalDone <= 1'b0;
        end
        else
        begin
            state <= next_state;
            if (state == ST_CAL)
                calCount <= calCount + 10'h001;
            else
                calCount <= 10'h000;
            if (state == ST_CAL && next_state != ST_CAL && next_state != ST_STANDBY)
                firstCalDone <= 1'b1;
        end
    end

    // Recovered clock tail after receive select falls
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tailCount   <= 8'h00;
            clockTailOn <= 1'b0;
        end
        else if (rxSelPrev && !receive_select_pin)
        begin
            tailCount   <= 8'h00;
            clockTailOn <= 1'b1;
        end
        else if (clockTailOn)
        begin
            if (tailCount == `TMC_CLKTAIL_LAST)
                clockTailOn <= 1'b0;
            tailCount <= tailCount + 8'h01;
        end
    end

    // Registered pin drivers
    always @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            tr_switch_pos_out    <= 1'b0;
            tr_switch_neg_out    <= 1'b0;
            power_amplifier_en   <= 1'b0;
            receiver_power_en    <= 1'b0;
            transmitter_power_en <= 1'b0;
            calibration_active   <= 1'b0;
            if_freq_select       <= `TMC_IF_864K;
            data_out_pin         <= 1'b0;
            slicer_tc_select_out <= 1'b0;
            slicer_tc_select_oe  <= 1'b0;
            slicer_tc_long       <= 1'b0;
        end
        else
        begin
            receiver_power_en    <= (state == ST_RX);
            transmitter_power_en <= (state == ST_TX);
            calibration_active   <= (state == ST_CAL);
            if_freq_select       <= rate_to_if(rateField);
            // Amplifier waits for lock so no off-channel energy is radiated
            power_amplifier_en   <= (state == ST_TX) && synth_locked;
            data_out_pin         <= (state == ST_RX) ? slicer_bit : 1'b0;
            if (synth_locked && state == ST_TX)
                tr_switch_pos_out <= 1'b1;
            else
                tr_switch_pos_out <= 1'b0;
            if (cfgReg[`TMC_CFG_PINSEL_BIT] && clockRecOk)
            begin
                if (state == ST_RX || clockTailOn)
                    tr_switch_neg_out <= recovered_clock_raw;
                else
                    tr_switch_neg_out <= 1'b1;
            end
            else if (synth_locked && state == ST_RX)
                tr_switch_neg_out <= 1'b1;
            else
                tr_switch_neg_out <= 1'b0;
            if (slicer_mode(testField))
            begin
                slicer_tc_select_oe  <= 1'b0;
                slicer_tc_select_out <= 1'b0;
                slicer_tc_long       <= !slicer_tc_select_in;
            end
            else
            begin
                slicer_tc_select_oe  <= 1'b1;
                slicer_tc_select_out <= synth_locked;
                slicer_tc_long       <= 1'b0;
            end
        end
    end
endmodule // tmc_mode_ctrl

// [test/tmc_host_model.sv]
// Baseband host model: mode pins and three-wire serial bus
module tmc_host_model (
    input  logic ref_clk,
    output logic chip_enable_pin,
    output logic receive_select_pin,
    output logic ser_clk,
    output logic ser_data,
    output logic ser_en
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        chip_enable_pin    = 1'b0;
        receive_select_pin = 1'b0;
        ser_clk            = 1'b0;
        ser_data           = 1'b1;
        ser_en             = 1'b1;
    end

    task automatic set_mode(input logic ce, input logic rx);
        @(posedge ref_clk);
        chip_enable_pin    <= ce;
        receive_select_pin <= rx;
    endtask

    // Each clock level is held two cycles and each data bit four, because the block samples the bus on its own clock
    task automatic send_word(input logic [23:0] w);
        @(posedge ref_clk);
        ser_en <= 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge ref_clk);
            ser_data <= w[i];
            @(posedge ref_clk);
            ser_clk <= 1'b1;
            repeat (2) @(posedge ref_clk);
            ser_clk <= 1'b0;
        end
        @(posedge ref_clk);
        ser_en   <= 1'b1;
        // Released data line shows the inverse so a stale bit cannot pass
        ser_data <= ~w[0];
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
endmodule // tmc_host_model

// [test/tmc_mode_ctrl_properties.sv]
// Port-level checker for the transceiver mode control block
module tmc_mode_ctrl_properties (
    input wire        ref_clk,
    input wire        rst_n,
    input wire        chip_enable_pin,
    input wire        synth_locked,
    input wire        slicer_bit,
    input wire        slicer_tc_select_in,
    input wire        slicer_tc_select_out,
    input wire        slicer_tc_select_oe,
    input wire        slicer_tc_long,
    input wire        tr_switch_pos_out,
    input wire        power_amplifier_en,
    input wire        receiver_power_en,
    input wire        transmitter_power_en,
    input wire        calibration_active,
    input wire        data_out_pin,
    input wire        ser_en,
    input wire [22:0] synth_freq_word
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    logic [9:0] calCnt;

    always @(posedge ref_clk)
    begin
        if (!rst_n || !calibration_active)
            calCnt <= 10'h000;
        else
            calCnt <= calCnt + 10'h001;
    end

    sequence s_standby;
        !chip_enable_pin [*3];
    endsequence

    sequence s_unlocked;
        !synth_locked [*3];
    endsequence

    AST_STANDBY_OFF: assert property (
        s_standby |-> !receiver_power_en && !transmitter_power_en)
        else $error("Radio powered in standby");
    AST_AMP_LOCK: assert property (s_unlocked |-> !power_amplifier_en)
        else $error("Amplifier on while unlocked");
    AST_AMP_TX: assert property (power_amplifier_en |-> transmitter_power_en)
        else $error("Amplifier on outside transmit");
    AST_SW_IDLE: assert property (s_unlocked |-> !tr_switch_pos_out)
        else $error("Switch active while unlocked");
    AST_POS_RX: assert property (tr_switch_pos_out |-> !receiver_power_en)
        else $error("Positive switch high in receive");
    AST_LOCK_PIN: assert property (
        (slicer_tc_select_oe && $stable(synth_locked)) [*3]
        |-> slicer_tc_select_out == synth_locked)
        else $error("Lock pin does not follow lock");
    AST_SLICER_TC: assert property (
        (!slicer_tc_select_oe && $stable(slicer_tc_select_in)) [*3]
        |-> slicer_tc_long == !slicer_tc_select_in)
        else $error("Slicer constant does not follow pin");
    AST_DATA_OUT: assert property (
        data_out_pin == (receiver_power_en && $past(slicer_bit)))
        else $error("Data output wrong");
    // A run that hands over to receive or transmit lasts 500 cycles; standby may cut it
    AST_CAL_LEN: assert property (
        $fell(calibration_active) && (receiver_power_en || transmitter_power_en)
        |-> calCnt == 10'h1f4)
        else $error("Calibration length wrong");
    AST_FREQ_EN: assert property ($changed(synth_freq_word) |-> ser_en)
        else $error("Frequency changed with enable low");
endmodule // tmc_mode_ctrl_properties

// [test/testbench.sv]
// Self-checking bench for the transceiver mode control block
`include "tmc_defs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, chip_enable_pin, receive_select_pin;
    logic        ser_clk, ser_data, ser_en, synth_locked = 1'b0, slicer_bit = 1'b0;
    logic        recovered_clock_raw = 1'b0, slicer_tc_select_in = 1'b1;
    logic        slicer_tc_select_out, slicer_tc_select_oe, slicer_tc_long;
    logic        tr_switch_pos_out, tr_switch_neg_out, power_amplifier_en;
    logic        receiver_power_en, transmitter_power_en, calibration_active, data_out_pin;
    logic [1:0]  if_freq_select;
    logic [1:0]  ifTab [5] = '{`TMC_IF_864K, `TMC_IF_864K, `TMC_IF_1024K,
                               `TMC_IF_2048K, `TMC_IF_2048K};
    logic [22:0] synth_freq_word;
    logic [2:0]  pat = 3'h0;
    int          n_errors = 0, n_compared = 0, k, tog;

    always #20 ref_clk = ~ref_clk;

    always @(posedge ref_clk)
    begin
        pat                 <= pat + 3'h1;
        slicer_bit          <= pat[2];
        recovered_clock_raw <= pat[0];
    end

    tmc_host_model i_host (.*);
    tmc_mode_ctrl i_dut (.*);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic bound(input int lim);
        if (k >= lim)
        begin
            n_errors++;
            $display("[FAIL] %0t ns: wait ran out", $time);
            final_report();
        end
    endtask

    task automatic wait_hi(ref logic s, input logic lvl, input int lim);
        for (k = 0; k < lim && s !== lvl; k++)
            @(negedge ref_clk);
        bound(lim);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        bound(20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check(err, e);
    endtask

    task automatic done(input string s);
        $display("Test %s ended, %0d mismatches so far", s, n_errors);
    endtask

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdchk(`TMC_ADDR_CTRL, 32'h0, 1'b0);
        rdchk(`TMC_ADDR_CONFIG, 32'h0, 1'b0);
        rdchk(12'h010, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h1234);
        check(err, 1'b1);
        done("reset");
        i_host.send_word(24'hd2b4c3);
        check(synth_freq_word, 23'h52b4c3);
        rdchk(`TMC_ADDR_FREQ, 32'h52b4c3, 1'b0);
        for (int r = 0; r < 5; r++)
        begin
            i_host.send_word({18'h0, r[2:0], 3'h0});
            check(if_freq_select, ifTab[r]);
        end
        rdchk(`TMC_ADDR_CONFIG, 32'h20, 1'b0);
        done("serial");
        synth_locked <= 1'b1;
        i_host.set_mode(1'b0, 1'b1);
        repeat (5) @(negedge ref_clk);
        check(receiver_power_en, 1'b0);
        i_host.set_mode(1'b1, 1'b1);
        wait_hi(receiver_power_en, 1'b1, 1500);
        repeat (3) @(negedge ref_clk);
        check({tr_switch_pos_out, tr_switch_neg_out, power_amplifier_en}, 3'b010);
        i_host.set_mode(1'b1, 1'b0);
        wait_hi(transmitter_power_en, 1'b1, 50);
        repeat (3) @(negedge ref_clk);
        check({tr_switch_pos_out, tr_switch_neg_out, power_amplifier_en}, 3'b101);
        @(posedge ref_clk);
        synth_locked <= 1'b0;
        repeat (3) @(negedge ref_clk);
        check({tr_switch_pos_out, tr_switch_neg_out, power_amplifier_en}, 3'b000);
        check(slicer_tc_select_out, 1'b0);
        @(posedge ref_clk);
        synth_locked <= 1'b1;
        done("mode");
        i_host.set_mode(1'b0, 1'b0);
        for (int t = 7; t >= 0; t--)
        begin
            i_host.send_word({21'h0, t[2:0]});
            check(slicer_tc_select_oe, !(t == 4 || t == 5));
            if (t == 4 || t == 5)
            begin
                @(posedge ref_clk);
                slicer_tc_select_in <= 1'b0;
                repeat (3) @(negedge ref_clk);
                check(slicer_tc_long, 1'b1);
                @(posedge ref_clk);
                slicer_tc_select_in <= 1'b1;
            end
        end
        check(slicer_tc_select_out, 1'b1);
        done("lock pin");
        i_host.send_word(24'h0000c8);
        apb(1'b0, `TMC_ADDR_STATUS, 32'h0);
        check(rd[6], 1'b1);
        i_host.set_mode(1'b1, 1'b1);
        wait_hi(receiver_power_en, 1'b1, 1500);
        tog = 0;
        repeat (20) @(negedge ref_clk) tog += tr_switch_neg_out;
        check(tog > 0 && tog < 20, 1'b1);
        i_host.set_mode(1'b1, 1'b0);
        tog = 0;
        repeat (100) @(negedge ref_clk) tog += tr_switch_neg_out;
        check(tog > 0 && tog < 100, 1'b1);
        repeat (110) @(negedge ref_clk);
        tog = 0;
        repeat (50) @(negedge ref_clk) tog += tr_switch_neg_out;
        check(tog, 50);
        i_host.set_mode(1'b0, 1'b0);
        i_host.send_word(24'h0000c0);
        apb(1'b0, `TMC_ADDR_STATUS, 32'h0);
        check(rd[6], 1'b0);
        done("recovered clock");
        i_host.set_mode(1'b1, 1'b1);
        wait_hi(receiver_power_en, 1'b1, 1500);
        apb(1'b1, `TMC_ADDR_CTRL, 32'h1);
        wait_hi(calibration_active, 1'b1, 5100);
        wait_hi(calibration_active, 1'b0, 600);
        apb(1'b1, `TMC_ADDR_CTRL, 32'h10000);
        rdchk(`TMC_ADDR_CTRL, 32'h0, 1'b0);
        wait_hi(calibration_active, 1'b1, 20);
        wait_hi(calibration_active, 1'b0, 600);
        rdchk(`TMC_ADDR_STATUS, 32'he, 1'b0);
        done("calibration");
        final_report();
    end
endmodule // testbench

bind tmc_mode_ctrl tmc_mode_ctrl_properties u_props (.*);
